/* design/fpc_pkg.sv */
`default_nettype none
package fpc_pkg;
  // register addresses on the special-function port
  localparam logic [7:0] FPC_CTL_ADDR = 8'h8f;
  localparam logic [7:0] FPC_KEY_ADDR = 8'hb6;
  // control field positions and reset value
  localparam int         FPC_WE_BIT   = 0;
  localparam int         FPC_EE_BIT   = 1;
  localparam int         FPC_SEL_BIT  = 2;
  localparam logic [2:0] FPC_CTL_RST  = 3'h0;
  localparam logic [4:0] FPC_CTL_PAD  = 5'h00;
  localparam logic [5:0] FPC_KEY_PAD  = 6'h00;
  localparam logic [7:0] FPC_RD_ZERO  = 8'h00;
  localparam logic [7:0] FPC_DATA_ZERO = 8'h00;
  // unlock keys, values arbitrary
  localparam logic [7:0] FPC_KEY_FIRST  = 8'h5a;
  localparam logic [7:0] FPC_KEY_SECOND = 8'h3c;

  // read-back order matters: the last state reads as 2'b11
  typedef enum logic [1:0] {
    fpc_wait_first,
    fpc_wait_second,
    fpc_open,
    fpc_locked
  } fpc_lock_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpc_core_req_t;

  typedef struct packed {
    logic        rd;
    logic        prog;
    logic        erase;
    logic        scratch;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpc_flash_cmd_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpc_xram_cmd_t;

  typedef struct packed {
    logic [2:0]     ctl;
    fpc_lock_t      lock;
    logic [7:0]     rdata;
    fpc_flash_cmd_t flash;
    fpc_xram_cmd_t  xram;
    logic           err_rst;
  } fpc_state_t;

  localparam fpc_state_t FPC_STATE_RST = '{
    ctl:     FPC_CTL_RST,
    lock:    fpc_wait_first,
    rdata:   FPC_RD_ZERO,
    flash:   '0,
    xram:    '0,
    err_rst: 1'b0
  };
endpackage : fpc_pkg
`default_nettype wire

/* design/fpc_flash_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module fpc_flash_ctrl (
  input  wire logic                   mclk,        // system clock
  input  wire logic                   reset_n,     // async reset
  input  wire logic [7:0]             reg_addr,    // register address
  input  wire logic [7:0]             reg_wdata,   // register write data
  input  wire logic                   reg_wr,      // register write strobe
  input  wire logic                   reg_rd,      // register read strobe
  output var  logic [7:0]             reg_rdata,   // read data, next cycle
  input  wire fpc_pkg::fpc_core_req_t core_req,    // core code read / data write
  input  wire logic                   vdd_mon_en,  // supply monitor on
  input  wire logic                   vdd_rst_en,  // monitor reset source on
  output var  fpc_pkg::fpc_flash_cmd_t flash_cmd,  // flash array command
  output var  fpc_pkg::fpc_xram_cmd_t  xram_cmd,   // external data write
  output var  logic                   flash_err_rst // error reset pulse
);
  import fpc_pkg::*;

  logic       rst_meta;
  logic       rst_n_q;
  fpc_state_t s_reg;
  fpc_state_t s_next;
  logic       we;
  logic       ee;
  logic       sel;
  logic       mon_ok;

  // reset release through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_q  <= rst_meta;
    end
  end

  assign we     = s_reg.ctl[FPC_WE_BIT];
  assign ee     = s_reg.ctl[FPC_EE_BIT];
  assign sel    = s_reg.ctl[FPC_SEL_BIT];
  assign mon_ok = vdd_mon_en && vdd_rst_en;

  always_comb begin
    s_next             = s_reg;
    s_next.rdata       = FPC_RD_ZERO;
    s_next.flash.rd    = 1'b0;
    s_next.flash.prog  = 1'b0;
    s_next.flash.erase = 1'b0;
    s_next.xram.wr     = 1'b0;
    s_next.err_rst     = 1'b0;

    // register writes
    if (reg_wr && reg_addr == FPC_CTL_ADDR) begin
      s_next.ctl = reg_wdata[FPC_SEL_BIT:FPC_WE_BIT];
    end
    if (reg_wr && reg_addr == FPC_KEY_ADDR) begin
      unique case (s_reg.lock)
        fpc_wait_first: begin
          s_next.lock = (reg_wdata == FPC_KEY_FIRST) ? fpc_wait_second
                                                     : fpc_locked;
        end
        fpc_wait_second: begin
          s_next.lock = (reg_wdata == FPC_KEY_SECOND) ? fpc_open
                                                      : fpc_locked;
        end
        fpc_open: begin
          s_next.lock = fpc_locked;
        end
        fpc_locked: begin
          s_next.lock = fpc_locked;
        end
      endcase
    end

    // register reads
    if (reg_rd) begin
      if (reg_addr == FPC_CTL_ADDR) begin
        s_next.rdata = {FPC_CTL_PAD, s_reg.ctl};
      end else if (reg_addr == FPC_KEY_ADDR) begin
        s_next.rdata = {FPC_KEY_PAD, s_reg.lock};
      end
    end

    // code-space reads follow the sector select
    if (core_req.rd) begin
      s_next.flash.rd      = 1'b1;
      s_next.flash.addr    = core_req.addr;
      s_next.flash.scratch = sel;
    end

    // data-space writes
    if (core_req.wr) begin
      if (!we) begin
        s_next.xram.wr    = 1'b1;
        s_next.xram.addr  = core_req.addr;
        s_next.xram.wdata = core_req.wdata;
      end else if (!mon_ok) begin
        s_next.err_rst = 1'b1;
      end else if (s_reg.lock == fpc_open) begin
        s_next.flash.addr    = core_req.addr;
        s_next.flash.scratch = sel;
        s_next.lock          = fpc_wait_first;
        if (ee) begin
          s_next.flash.erase = 1'b1;
          s_next.flash.wdata = FPC_DATA_ZERO;
        end else begin
          s_next.flash.prog  = 1'b1;
          s_next.flash.wdata = core_req.wdata;
        end
      end else begin
        // key sequence not complete: refuse and lock
        s_next.lock = fpc_locked;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_reg <= FPC_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata     = s_reg.rdata;
  assign flash_cmd     = s_reg.flash;
  assign xram_cmd      = s_reg.xram;
  assign flash_err_rst = s_reg.err_rst;

  // checks
  property p_ctl_pad;
    @(posedge mclk) disable iff (!rst_n_q)
    reg_rd && reg_addr == FPC_CTL_ADDR
      |=> reg_rdata[7:3] == FPC_CTL_PAD
          && reg_rdata[2:0] == $past(s_reg.ctl);
  endproperty
  a_ctl_pad: assert property (p_ctl_pad)
    else $error("control read shows bad bits");

  property p_sel_scratch;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.rd && sel |=> flash_cmd.rd && flash_cmd.scratch;
  endproperty
  a_sel_scratch: assert property (p_sel_scratch)
    else $error("read not sent to scratchpad");

  property p_sel_main;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.rd && !sel
      |=> flash_cmd.rd && !flash_cmd.scratch
          && flash_cmd.addr == $past(core_req.addr);
  endproperty
  a_sel_main: assert property (p_sel_main)
    else $error("read not sent to main sector");

  property p_erase;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && we && ee && mon_ok && s_reg.lock == fpc_open
      |=> flash_cmd.erase && !flash_cmd.prog && !xram_cmd.wr
          && s_reg.lock == fpc_wait_first;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase not issued");

  property p_erase_data;
    @(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.erase |-> flash_cmd.wdata == FPC_DATA_ZERO;
  endproperty
  a_erase_data: assert property (p_erase_data)
    else $error("erase carries data");

  property p_prog;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && we && !ee && mon_ok && s_reg.lock == fpc_open
      |=> flash_cmd.prog && !flash_cmd.erase
          && flash_cmd.wdata == $past(core_req.wdata);
  endproperty
  a_prog: assert property (p_prog)
    else $error("byte not programmed");

  property p_no_we;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && !we
      |=> xram_cmd.wr && !flash_cmd.prog && !flash_cmd.erase;
  endproperty
  a_no_we: assert property (p_no_we)
    else $error("flash touched with writes off");

  property p_no_ee;
    @(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.erase |-> $past(ee) && $past(we);
  endproperty
  a_no_ee: assert property (p_no_ee)
    else $error("erase without enable");

  property p_locked;
    @(posedge mclk) disable iff (!rst_n_q)
    s_reg.lock == fpc_locked
      |=> s_reg.lock == fpc_locked && !flash_cmd.prog && !flash_cmd.erase;
  endproperty
  a_locked: assert property (p_locked)
    else $error("lock released or write passed");

  property p_err_rst;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && we && !mon_ok
      |=> flash_err_rst
          ##1 (!flash_err_rst || $past(core_req.wr && we && !mon_ok));
  endproperty
  a_err_rst: assert property (p_err_rst)
    else $error("no error reset pulse");

  property p_bad_key;
    @(posedge mclk) disable iff (!rst_n_q)
    reg_wr && reg_addr == FPC_KEY_ADDR && !core_req.wr
      && s_reg.lock == fpc_wait_first && reg_wdata != FPC_KEY_FIRST
      |=> s_reg.lock == fpc_locked;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("wrong key did not lock");

  property p_rdata_idle;
    @(posedge mclk) disable iff (!rst_n_q)
    !reg_rd |=> reg_rdata == FPC_RD_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  property p_ctl_write;
    @(posedge mclk) disable iff (!rst_n_q)
    reg_wr && reg_addr == FPC_CTL_ADDR
      |=> s_reg.ctl == $past(reg_wdata[FPC_SEL_BIT:FPC_WE_BIT]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not taken");

  property p_key_read;
    @(posedge mclk) disable iff (!rst_n_q)
    reg_rd && reg_addr == FPC_KEY_ADDR
      |=> reg_rdata == {FPC_KEY_PAD, $past(s_reg.lock)};
  endproperty
  a_key_read: assert property (p_key_read)
    else $error("lock state read back wrong");

  property p_unmapped;
    @(posedge mclk) disable iff (!rst_n_q)
    reg_rd && reg_addr != FPC_CTL_ADDR && reg_addr != FPC_KEY_ADDR
      |=> reg_rdata == FPC_RD_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_wr_sector;
    @(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.prog || flash_cmd.erase |-> flash_cmd.scratch == $past(sel);
  endproperty
  a_wr_sector: assert property (p_wr_sector)
    else $error("flash write sent to wrong sector");

  property p_scratch_addr;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.rd && sel && !core_req.wr
      |=> flash_cmd.addr == $past(core_req.addr);
  endproperty
  a_scratch_addr: assert property (p_scratch_addr)
    else $error("scratchpad read address lost");

  property p_xram_data;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && !we
      |=> xram_cmd.addr == $past(core_req.addr)
          && xram_cmd.wdata == $past(core_req.wdata);
  endproperty
  a_xram_data: assert property (p_xram_data)
    else $error("external write carries wrong word");

  property p_flash_needs_we;
    @(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.prog || flash_cmd.erase |-> $past(we);
  endproperty
  a_flash_needs_we: assert property (p_flash_needs_we)
    else $error("flash changed with writes off");

  property p_needs_open;
    @(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.prog || flash_cmd.erase |-> $past(s_reg.lock) == fpc_open;
  endproperty
  a_needs_open: assert property (p_needs_open)
    else $error("flash changed without a key");

  property p_err_no_flash;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && we && !mon_ok
      |=> !flash_cmd.prog && !flash_cmd.erase && !xram_cmd.wr;
  endproperty
  a_err_no_flash: assert property (p_err_no_flash)
    else $error("write passed with monitor off");

  property p_err_cause;
    @(posedge mclk) disable iff (!rst_n_q)
    flash_err_rst |-> $past(we) && !$past(mon_ok);
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("error reset without cause");

  property p_unkeyed;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && we && mon_ok && s_reg.lock != fpc_open
      |=> s_reg.lock == fpc_locked && !flash_cmd.prog && !flash_cmd.erase;
  endproperty
  a_unkeyed: assert property (p_unkeyed)
    else $error("unkeyed write did not lock");

  property p_bad_second;
    @(posedge mclk) disable iff (!rst_n_q)
    reg_wr && reg_addr == FPC_KEY_ADDR && !core_req.wr
      && s_reg.lock == fpc_wait_second && reg_wdata != FPC_KEY_SECOND
      |=> s_reg.lock == fpc_locked;
  endproperty
  a_bad_second: assert property (p_bad_second)
    else $error("wrong second key did not lock");

  property p_op_addr;
    @(posedge mclk) disable iff (!rst_n_q)
    core_req.wr && we && mon_ok && s_reg.lock == fpc_open
      |=> flash_cmd.addr == $past(core_req.addr);
  endproperty
  a_op_addr: assert property (p_op_addr)
    else $error("flash operation address lost");

  property p_one_op;
    @(posedge mclk) disable iff (!rst_n_q)
    !(flash_cmd.prog && flash_cmd.erase);
  endproperty
  a_one_op: assert property (p_one_op)
    else $error("erase and program at once");

  c_read_scratch: cover property (@(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.rd && flash_cmd.scratch);
  c_erase: cover property (@(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.erase);
  c_prog_scratch: cover property (@(posedge mclk) disable iff (!rst_n_q)
    flash_cmd.prog && flash_cmd.scratch);
  c_err: cover property (@(posedge mclk) disable iff (!rst_n_q)
    flash_err_rst);
  c_lock: cover property (@(posedge mclk) disable iff (!rst_n_q)
    s_reg.lock == fpc_locked);
endmodule : fpc_flash_ctrl
`default_nettype wire

/* tb/fpc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fpc_core_model (
  input  wire logic                   mclk,        // system clock
  input  wire fpc_pkg::fpc_core_req_t req_in,      // request from bench
  input  wire logic                   scratch_sel, // scratchpad sector chosen
  output var  fpc_pkg::fpc_core_req_t core_req     // request to controller
);
  import fpc_pkg::*;
  // one-cycle pipeline, like the core's issue stage
  always_ff @(posedge mclk) begin
    core_req <= '{wr: req_in.wr, rd: req_in.rd, wdata: req_in.wdata,
                  addr: scratch_sel ? {7'h00, req_in.addr[8:0]} : req_in.addr};
  end
endmodule : fpc_core_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fpc_pkg::*;
  logic           mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic           mon = 1'b1, rst_en = 1'b1, sel = 1'b0, rd_prev = 1'b0;
  logic [7:0]     reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [15:0]    a;
  fpc_core_req_t  req = '0, core_req;
  fpc_flash_cmd_t flash_cmd;
  fpc_xram_cmd_t  xram_cmd;
  logic           flash_err_rst;
  logic [27:0]    exq[$];
  int             mismatches = 0, checked = 0, cyc = 0;

  fpc_core_model core_u (.mclk(mclk), .req_in(req), .scratch_sel(sel), .core_req(core_req));
  fpc_flash_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_req(core_req), .vdd_mon_en(mon), .vdd_rst_en(rst_en), .flash_cmd(flash_cmd),
    .xram_cmd(xram_cmd), .flash_err_rst(flash_err_rst));

  always #50 mclk = ~mclk;

  task automatic end_of_test;
    if (exq.size() != 0) begin
      $display("CHECK FAILED pending_results expected 0 seen %0d", exq.size());
      mismatches++;
    end
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  always @(posedge mclk) begin
    rd_prev = reg_rd;
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // result word: kind, sector, address, data
  task automatic chk(input logic [27:0] g);
    logic [27:0] e;
    checked++;
    e = (exq.size() != 0) ? exq.pop_front() : 28'h0;
    if (e !== g) begin
      $display("CHECK FAILED result expected %h seen %h", e, g);
      mismatches++;
    end
  endtask : chk

  always @(negedge mclk) begin
    if (rd_prev) chk({3'd6, 1'b0, 16'h0000, reg_rdata});
    if (flash_cmd.rd === 1'b1) chk({3'd1, flash_cmd.scratch, flash_cmd.addr, 8'h00});
    if (flash_cmd.prog === 1'b1) chk({3'd2, flash_cmd.scratch, flash_cmd.addr, flash_cmd.wdata});
    if (flash_cmd.erase === 1'b1) chk({3'd3, flash_cmd.scratch, flash_cmd.addr, flash_cmd.wdata});
    if (xram_cmd.wr === 1'b1) chk({3'd4, 1'b0, xram_cmd.addr, xram_cmd.wdata});
    if (flash_err_rst === 1'b1) chk({3'd5, 1'b0, 16'h0000, 8'h00});
  end

  function automatic logic [15:0] ma(input logic s, input logic [15:0] ad);
    return s ? {7'h00, ad[8:0]} : ad;
  endfunction : ma

  task automatic put(input logic [2:0] k, input logic s, input logic [15:0] ad,
                     input logic [7:0] dt);
    exq.push_back({k, s, ad, dt});
  endtask : put

  task automatic reg_w(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= dt;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : reg_w

  task automatic reg_r(input logic [7:0] ad, input logic [7:0] ex);
    put(3'd6, 1'b0, 16'h0000, ex);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(posedge mclk);
  endtask : reg_r

  task automatic set_ctl(input logic [7:0] v);
    reg_w(FPC_CTL_ADDR, v);
    sel <= v[FPC_SEL_BIT];
  endtask : set_ctl

  task automatic core(input logic w, input logic r);
    @(posedge mclk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
    repeat (3) @(posedge mclk);
  endtask : core

  task automatic unlock;
    reg_w(FPC_KEY_ADDR, FPC_KEY_FIRST);
    reg_w(FPC_KEY_ADDR, FPC_KEY_SECOND);
  endtask : unlock

  initial begin
    d = 8'($urandom(32'hafd7));
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    reg_r(FPC_CTL_ADDR, 8'h00);
    reg_r(FPC_KEY_ADDR, 8'h00);
    reg_r(8'h10, 8'h00);
    set_ctl(8'hff);
    reg_r(FPC_CTL_ADDR, 8'h07);
    for (int i = 0; i < 4; i++) begin
      a = 16'($urandom());
      d = 8'($urandom());
      set_ctl({5'h1f, i[0], i[1], 1'b0});
      put(3'd4, 1'b0, ma(i[0], a), d);
      core(1'b1, 1'b0);
      put(3'd1, i[0], ma(i[0], a), 8'h00);
      core(1'b0, 1'b1);
    end
    for (int i = 3; i >= 0; i--) begin // erase before programming
      a = 16'($urandom());
      d = 8'($urandom());
      set_ctl({5'h00, i[0], i[1], 1'b1});
      unlock();
      reg_r(FPC_KEY_ADDR, 8'h02);
      put(i[1] ? 3'd3 : 3'd2, i[0], ma(i[0], a), i[1] ? 8'h00 : d);
      core(1'b1, 1'b0);
      reg_r(FPC_KEY_ADDR, 8'h00);
    end
    set_ctl(8'h01);
    for (int j = 0; j < 2; j++) begin
      {mon, rst_en} <= j[0] ? 2'b10 : 2'b01;
      reg_r(FPC_KEY_ADDR, 8'h00);
      put(3'd5, 1'b0, 16'h0000, 8'h00);
      core(1'b1, 1'b0);
    end
    {mon, rst_en} <= 2'b11;
    reg_w(FPC_KEY_ADDR, 8'h00);
    core(1'b1, 1'b0);
    reg_r(FPC_KEY_ADDR, 8'h03);
    unlock();
    core(1'b1, 1'b0);
    reg_r(FPC_KEY_ADDR, 8'h03);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    reg_r(FPC_KEY_ADDR, 8'h00);
    reg_r(FPC_CTL_ADDR, 8'h00);
    repeat (4) @(posedge mclk);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
